// [rtl/tmrcc_map.svh]
// Register offsets, field positions, reset values and constants for the timer control core
`ifndef TMRCC_MAP_SVH
`define TMRCC_MAP_SVH

// ----------------------------------------
// Register offsets (byte registers)
// ----------------------------------------
`define TMRCC_OFS_STATUS_CONTROL 4'h0
`define TMRCC_OFS_COUNTER_HIGH 4'h1
`define TMRCC_OFS_COUNTER_LOW 4'h2
`define TMRCC_OFS_MODULO_HIGH 4'h3
`define TMRCC_OFS_MODULO_LOW 4'h4

// ----------------------------------------
// Status and control field positions
// ----------------------------------------
`define TMRCC_BIT_OVERFLOW_FLAG 7
`define TMRCC_BIT_OVERFLOW_IRQ_ENABLE 6
`define TMRCC_BIT_CENTER_ALIGNED_SELECT 5
`define TMRCC_CLKSEL_MSB 4
`define TMRCC_CLKSEL_LSB 3
`define TMRCC_PRESCALE_MSB 2
`define TMRCC_PRESCALE_LSB 0

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define TMRCC_RST_STATUS_CONTROL 8'h00
`define TMRCC_RST_COUNTER 16'h0000
`define TMRCC_RST_MODULO 16'h0000
`define TMRCC_COUNTER_ZERO 16'h0000
`define TMRCC_READ_ZERO 8'h00

`endif

// [rtl/tmrcc_pkg.sv]
// Types for the timer control core
package tmrcc_pkg;
   // Clock source selection codes
   typedef enum logic [1:0] {
      TMRCC_CLK_NONE = 2'h0,
      TMRCC_CLK_BUS = 2'h1,
      TMRCC_CLK_FIXED = 2'h2,
      TMRCC_CLK_EXT = 2'h3
   } tmrcc_clksel_t;

   // Coherency latch state
   typedef enum logic [1:0] {
      TMRCC_LATCH_ARMED,
      TMRCC_LATCH_HELD_HIGH_READ,
      TMRCC_LATCH_HELD_LOW_READ
   } tmrcc_latch_t;
endpackage

// [rtl/tmrcc_core.sv]
// Timer control core: status/control, prescaler, counter and read coherency latch
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tmrcc_map.svh"

// Contract
// - Overflow flag sets when counter wraps to zero after reaching modulo.
// - Flag clears only on read-while-set followed by writing zero to bit 7.
// - Overflow between qualifying read and write restarts clearing; flag stays set.
// - Writing one to the flag has no effect; reset clears it.
// - Interrupt request when flag and enable bit 6 both set; reset clears enable.
// - Bit 5 zero counts up; one counts up/down for center-aligned PWM.
// - Bits 4-3 select none, bus, fixed system or external clock.
// - Fixed clock behaves like bus clock when no PLL/FLL is enabled.
// - External clock is synchronised to the bus clock inside the block.
// - Prescale field divides selected clock by two to the field value.
// - Prescaler follows selection; new value acts on the next cycle.
// - Reading either counter byte buffers both; reading the other releases.
// - Coherent 16-bit read in either byte order.
// - Reset or any status/control write re-arms the read latch.
// - Any counter byte write clears the counter and re-arms the latch.
// - Reset clears the counter.
// - Debug halt freezes counter and latch state, even across counter reads.
// - In debug halt, status/control or counter writes still re-arm the latch.
// - After modulo, restart at zero; modulo zero means free-running.
module tmrcc_core #(
   parameter int PRESCALE_WIDTH = 7
) (
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic I_EXT_CLK,
   input wire logic I_FIXED_CLK_TICK,
   input wire logic I_FLL_PLL_ENABLED,
   input wire logic I_DEBUG_HALT,
   output logic [7:0] O_RDATA,
   output logic O_OVERFLOW_IRQ,
   output logic O_OVERFLOW_EVENT,
   output logic [15:0] O_COUNTER,
   output logic O_COUNT_DOWN,
   output logic O_CENTER_ALIGNED
);
   import tmrcc_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Software-visible control state
   logic overflow_flag_reg;
   logic overflow_irq_enable_reg;
   logic center_aligned_select_reg;
   tmrcc_clksel_t clock_source_select_reg;
   logic [2:0] prescale_select_reg;
   logic clear_armed_reg;

   // Counter, direction and read buffer
   logic [15:0] counter_reg;
   logic count_down_reg;
   logic [15:0] modulo_value_reg;
   logic [15:0] counter_buf_reg;
   tmrcc_latch_t latch_state_reg;

   // Synchroniser and prescaler stages
   logic ext_sync1_reg;
   logic ext_sync2_reg;
   logic ext_sync3_reg;
   logic fix_sync1_reg;
   logic fix_sync2_reg;
   logic halt_sync1_reg;
   logic halt_sync2_reg;
   logic pll_sync1_reg;
   logic pll_sync2_reg;
   logic [PRESCALE_WIDTH-1:0] prescale_cnt_reg;

   // Ticks, next values and decoded strobes
   logic src_tick;
   logic presc_tick;
   logic overflow_evt;
   logic [15:0] counter_next;
   logic count_down_next;
   logic wr_sc;
   logic wr_cnt;
   logic rd_sc;
   logic rd_hi;
   logic rd_lo;
   logic wr_mod_hi;
   logic wr_mod_lo;
   logic halted;
   logic [15:0] cnt_visible;

   // Mask of low prescaler bits that must all be one for a tick
   function automatic logic [PRESCALE_WIDTH-1:0] presc_mask(input logic [2:0] sel);
      logic [PRESCALE_WIDTH:0] one_hot;
      one_hot = '0;
      one_hot[sel] = 1'b1;
      presc_mask = one_hot[PRESCALE_WIDTH-1:0] - 1'b1;
   endfunction

   // Address decode helper
   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Counter value a byte read sees: live while armed, buffered while held
   function automatic logic [15:0] cnt_view(input tmrcc_latch_t st,
      input logic [15:0] live, input logic [15:0] held);
      logic [15:0] view;
      view = live;
      if (st != TMRCC_LATCH_ARMED) begin
         view = held;
      end
      cnt_view = view;
   endfunction

   // ----------------------------------------
   // Register access decode
   // ----------------------------------------
   assign wr_sc = I_WR && hit(I_ADDR, `TMRCC_OFS_STATUS_CONTROL);
   assign rd_sc = I_RD && hit(I_ADDR, `TMRCC_OFS_STATUS_CONTROL);
   assign rd_hi = I_RD && hit(I_ADDR, `TMRCC_OFS_COUNTER_HIGH);
   assign rd_lo = I_RD && hit(I_ADDR, `TMRCC_OFS_COUNTER_LOW);
   assign wr_cnt = I_WR && (hit(I_ADDR, `TMRCC_OFS_COUNTER_HIGH) ||
                            hit(I_ADDR, `TMRCC_OFS_COUNTER_LOW));
   assign wr_mod_hi = I_WR && hit(I_ADDR, `TMRCC_OFS_MODULO_HIGH);
   assign wr_mod_lo = I_WR && hit(I_ADDR, `TMRCC_OFS_MODULO_LOW);
   assign halted = halt_sync2_reg;

   // Counter value a byte read sees
   assign cnt_visible = cnt_view(latch_state_reg, counter_reg, counter_buf_reg);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Two-stage synchronisers, plus a third stage for external edge detect
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         ext_sync1_reg <= 1'b0;
         ext_sync2_reg <= 1'b0;
         ext_sync3_reg <= 1'b0;
         fix_sync1_reg <= 1'b0;
         fix_sync2_reg <= 1'b0;
         halt_sync1_reg <= 1'b0;
         halt_sync2_reg <= 1'b0;
         pll_sync1_reg <= 1'b0;
         pll_sync2_reg <= 1'b0;
      end else begin
         ext_sync1_reg <= I_EXT_CLK;
         ext_sync2_reg <= ext_sync1_reg;
         ext_sync3_reg <= ext_sync2_reg;
         fix_sync1_reg <= I_FIXED_CLK_TICK;
         fix_sync2_reg <= fix_sync1_reg;
         halt_sync1_reg <= I_DEBUG_HALT;
         halt_sync2_reg <= halt_sync1_reg;
         pll_sync1_reg <= I_FLL_PLL_ENABLED;
         pll_sync2_reg <= pll_sync1_reg;
      end
   end

   // ----------------------------------------
   // Clock source selection and prescaler
   // ----------------------------------------
   // Source tick for the prescaler input
   always_comb begin
      case (clock_source_select_reg)
         TMRCC_CLK_NONE: src_tick = 1'b0;
         TMRCC_CLK_BUS: src_tick = 1'b1;
         TMRCC_CLK_FIXED: src_tick = pll_sync2_reg ? fix_sync2_reg : 1'b1;
         TMRCC_CLK_EXT: src_tick = ext_sync2_reg && !ext_sync3_reg;
         default: src_tick = 1'b0;
      endcase
   end

   // Prescaler tick uses the current select value directly
   // Divider is not cleared on a select change, so the first tick may come early
   assign presc_tick = src_tick && !halted &&
      ((prescale_cnt_reg & presc_mask(prescale_select_reg)) ==
       presc_mask(prescale_select_reg));

   // Free prescaler counter after the source selection
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         prescale_cnt_reg <= '0;
      end else if (wr_cnt) begin
         prescale_cnt_reg <= '0;
      end else if (src_tick && !halted) begin
         prescale_cnt_reg <= prescale_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // Counter next value
   // ----------------------------------------
   // Next count, direction and overflow for one prescaler tick
   always_comb begin
      counter_next = counter_reg;
      count_down_next = count_down_reg;
      overflow_evt = 1'b0;
      // Direction never lingers once up-only mode is chosen
      if (!center_aligned_select_reg) begin
         count_down_next = 1'b0;
      end
      if (presc_tick) begin
         if (!center_aligned_select_reg) begin
            count_down_next = 1'b0;
            if (modulo_value_reg != `TMRCC_COUNTER_ZERO && counter_reg == modulo_value_reg) begin
               counter_next = `TMRCC_COUNTER_ZERO;
               overflow_evt = 1'b1;
            end else begin
               counter_next = counter_reg + 16'h0001;
               overflow_evt = (counter_reg == 16'hFFFF);
            end
         end else if (count_down_reg) begin
            if (counter_reg == 16'h0001 || counter_reg == `TMRCC_COUNTER_ZERO) begin
               counter_next = `TMRCC_COUNTER_ZERO;
               count_down_next = 1'b0;
               overflow_evt = (counter_reg == 16'h0001);
            end else begin
               counter_next = counter_reg - 16'h0001;
            end
         end else if (counter_reg >= modulo_value_reg - 16'h0001 &&
                      modulo_value_reg != `TMRCC_COUNTER_ZERO) begin
            counter_next = counter_reg + 16'h0001;
            count_down_next = 1'b1;
         end else begin
            counter_next = counter_reg + 16'h0001;
            count_down_next = (counter_reg == 16'hFFFE);
         end
      end
   end

   // ----------------------------------------
   // Counter, direction and modulo state
   // ----------------------------------------
   // Counter writes win over counting
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         counter_reg <= `TMRCC_RST_COUNTER;
         count_down_reg <= 1'b0;
      end else if (wr_cnt) begin
         counter_reg <= `TMRCC_COUNTER_ZERO;
         count_down_reg <= 1'b0;
      end else begin
         counter_reg <= counter_next;
         count_down_reg <= count_down_next;
      end
   end

   // Modulo value, written per byte
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         modulo_value_reg <= `TMRCC_RST_MODULO;
      end else if (wr_mod_hi) begin
         modulo_value_reg[15:8] <= I_WDATA;
      end else if (wr_mod_lo) begin
         modulo_value_reg[7:0] <= I_WDATA;
      end
   end

   // ----------------------------------------
   // Status and control register
   // ----------------------------------------
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         overflow_irq_enable_reg <= 1'b0;
         center_aligned_select_reg <= 1'b0;
         clock_source_select_reg <= TMRCC_CLK_NONE;
         prescale_select_reg <= 3'h0;
      end else if (wr_sc) begin
         overflow_irq_enable_reg <= I_WDATA[`TMRCC_BIT_OVERFLOW_IRQ_ENABLE];
         center_aligned_select_reg <= I_WDATA[`TMRCC_BIT_CENTER_ALIGNED_SELECT];
         clock_source_select_reg <=
            tmrcc_clksel_t'(I_WDATA[`TMRCC_CLKSEL_MSB:`TMRCC_CLKSEL_LSB]);
         prescale_select_reg <= I_WDATA[`TMRCC_PRESCALE_MSB:`TMRCC_PRESCALE_LSB];
      end
   end

   // Overflow flag with read-then-write-zero clearing; set wins
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         overflow_flag_reg <= 1'b0;
         clear_armed_reg <= 1'b0;
      end else if (overflow_evt) begin
         overflow_flag_reg <= 1'b1;
         clear_armed_reg <= 1'b0;
      end else if (wr_sc) begin
         if (clear_armed_reg && !I_WDATA[`TMRCC_BIT_OVERFLOW_FLAG]) begin
            overflow_flag_reg <= 1'b0;
         end
         clear_armed_reg <= 1'b0;
      end else if (rd_sc && overflow_flag_reg) begin
         clear_armed_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // Counter read coherency latch
   // ----------------------------------------
   // Writes re-arm even in halt; reads are ignored while halted
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         latch_state_reg <= TMRCC_LATCH_ARMED;
         counter_buf_reg <= `TMRCC_RST_COUNTER;
      end else if (wr_sc || wr_cnt) begin
         latch_state_reg <= TMRCC_LATCH_ARMED;
      end else if (!halted) begin
         case (latch_state_reg)
            TMRCC_LATCH_ARMED: begin
               if (rd_hi) begin
                  latch_state_reg <= TMRCC_LATCH_HELD_HIGH_READ;
                  counter_buf_reg <= counter_reg;
               end else if (rd_lo) begin
                  latch_state_reg <= TMRCC_LATCH_HELD_LOW_READ;
                  counter_buf_reg <= counter_reg;
               end
            end
            TMRCC_LATCH_HELD_HIGH_READ: begin
               if (rd_lo) begin
                  latch_state_reg <= TMRCC_LATCH_ARMED;
               end
            end
            TMRCC_LATCH_HELD_LOW_READ: begin
               if (rd_hi) begin
                  latch_state_reg <= TMRCC_LATCH_ARMED;
               end
            end
            default: latch_state_reg <= TMRCC_LATCH_ARMED;
         endcase
      end
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   // Registered read mux, zero when no read is pending
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         O_RDATA <= `TMRCC_READ_ZERO;
      end else if (!I_RD) begin
         O_RDATA <= `TMRCC_READ_ZERO;
      end else begin
         case (I_ADDR)
            `TMRCC_OFS_STATUS_CONTROL: O_RDATA <= {overflow_flag_reg,
               overflow_irq_enable_reg, center_aligned_select_reg,
               clock_source_select_reg, prescale_select_reg};
            `TMRCC_OFS_COUNTER_HIGH: O_RDATA <= cnt_visible[15:8];
            `TMRCC_OFS_COUNTER_LOW: O_RDATA <= cnt_visible[7:0];
            `TMRCC_OFS_MODULO_HIGH: O_RDATA <= modulo_value_reg[15:8];
            `TMRCC_OFS_MODULO_LOW: O_RDATA <= modulo_value_reg[7:0];
            default: O_RDATA <= `TMRCC_READ_ZERO;
         endcase
      end
   end

   // ----------------------------------------
   // Outputs to channel logic
   // ----------------------------------------
   // Registered outputs mirror the next counter state
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         O_OVERFLOW_IRQ <= 1'b0;
         O_OVERFLOW_EVENT <= 1'b0;
         O_COUNTER <= `TMRCC_RST_COUNTER;
         O_COUNT_DOWN <= 1'b0;
         O_CENTER_ALIGNED <= 1'b0;
      end else begin
         O_OVERFLOW_IRQ <= (overflow_flag_reg || overflow_evt) &&
            overflow_irq_enable_reg;
         O_OVERFLOW_EVENT <= overflow_evt;
         O_COUNTER <= wr_cnt ? `TMRCC_COUNTER_ZERO : counter_next;
         O_COUNT_DOWN <= wr_cnt ? 1'b0 : count_down_next;
         O_CENTER_ALIGNED <= center_aligned_select_reg;
      end
   end
endmodule

// [bench/tmrcc_core_monitor.sv]
// Port-level assertions for the timer control core
`timescale 1ns/1ps
module tmrcc_core_monitor #(
   parameter int PRESCALE_WIDTH = 7
) (
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   input wire logic O_OVERFLOW_IRQ,
   input wire logic O_OVERFLOW_EVENT,
   input wire logic [15:0] O_COUNTER,
   input wire logic O_COUNT_DOWN,
   input wire logic O_CENTER_ALIGNED
);
   logic [6:0] sc_reg;
   logic cnt_wr;
   // Counter byte write strobe
   assign cnt_wr = I_WR && (I_ADDR == 4'h1 || I_ADDR == 4'h2);
   // Shadow of the written control bits
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         sc_reg <= 7'h00;
      end else if (I_WR && I_ADDR == 4'h0) begin
         sc_reg <= I_WDATA[6:0];
      end
   end
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);
   property p_sc_readback;
      I_RD && I_ADDR == 4'h0 |=> O_RDATA[6:0] == sc_reg;
   endproperty
   a_sc_readback: assert property (p_sc_readback) else $error("control readback");
   property p_irq_enable;
      O_OVERFLOW_IRQ |-> sc_reg[6] || $past(sc_reg[6]);
   endproperty
   a_irq_enable: assert property (p_irq_enable) else $error("irq while disabled");
   property p_irq_follows;
      O_OVERFLOW_EVENT && sc_reg[6] |-> ##[0:1] O_OVERFLOW_IRQ;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq missing");
   property p_event_zero;
      O_OVERFLOW_EVENT |-> O_COUNTER == 16'h0000 || $past(O_COUNTER) == 16'h0000;
   endproperty
   a_event_zero: assert property (p_event_zero) else $error("overflow not at zero");
   property p_cnt_clear;
      cnt_wr |-> ##[1:2] O_COUNTER == 16'h0000;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");
   property p_down_center;
      O_COUNT_DOWN |-> O_CENTER_ALIGNED || $past(O_CENTER_ALIGNED);
   endproperty
   a_down_center: assert property (p_down_center) else $error("down count in up mode");
   property p_center_follow;
      $changed(sc_reg[5]) |-> ##[1:2] O_CENTER_ALIGNED == sc_reg[5];
   endproperty
   a_center_follow: assert property (p_center_follow) else $error("mode not applied");
   property p_stopped;
      sc_reg[4:3] == 2'b00 && $past(sc_reg[4:3], 3) == 2'b00 && !cnt_wr && !$past(cnt_wr)
         |=> $stable(O_COUNTER);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved unclocked");
endmodule

bind tmrcc_core tmrcc_core_monitor #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) tmrcc_core_monitor_i (
   .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_OVERFLOW_IRQ(O_OVERFLOW_IRQ),
   .O_OVERFLOW_EVENT(O_OVERFLOW_EVENT), .O_COUNTER(O_COUNTER),
   .O_COUNT_DOWN(O_COUNT_DOWN), .O_CENTER_ALIGNED(O_CENTER_ALIGNED)
);

// [bench/timer_counter_control_core_tb.sv]
// Self-checking bench for the timer control core
`timescale 1ns/1ps
`include "tmrcc_map.svh"
module timer_counter_control_core_tb;
   localparam logic [3:0] SC = `TMRCC_OFS_STATUS_CONTROL;
   localparam logic [3:0] CH = `TMRCC_OFS_COUNTER_HIGH;
   localparam logic [3:0] CL = `TMRCC_OFS_COUNTER_LOW;
   localparam logic [3:0] ML = `TMRCC_OFS_MODULO_LOW;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic ext_clk = 1'b0;
   logic halt = 1'b0;
   logic fix_tick = 1'b0;
   logic pll_en = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, b1, b2;
   logic irq, evt, down, center, seen;
   logic [15:0] counter, v;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;

   // Device under test
   tmrcc_core #(.PRESCALE_WIDTH(7)) tmrcc_core_i (
      .I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(bus_wr),
      .I_RD(bus_rd), .I_EXT_CLK(ext_clk), .I_FIXED_CLK_TICK(fix_tick),
      .I_FLL_PLL_ENABLED(pll_en), .I_DEBUG_HALT(halt), .O_RDATA(rdata),
      .O_OVERFLOW_IRQ(irq), .O_OVERFLOW_EVENT(evt), .O_COUNTER(counter),
      .O_COUNT_DOWN(down), .O_CENTER_ALIGNED(center)
   );

   // Bus clock and an external clock of eight bus cycles
   always #50 clk = ~clk;
   always #400 ext_clk = ~ext_clk;

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         err_count++;
         end_of_test();
      end
   end

   // Verdict and end of run
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Exact and tolerant comparisons
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic near(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if ((^got === 1'bx) || (got > exp + 16'h3) || (got + 16'h3 < exp)) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Register bus cycles
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // Two-byte counter read, first byte chosen, gap between the bytes
   task automatic rd_cnt(input logic [3:0] first, input int gap, output logic [15:0] val);
      logic [7:0] a, b;
      reg_rd(first, a);
      repeat (gap) @(posedge clk);
      reg_rd(first ^ 4'h3, b);
      val = (first == CH) ? {a, b} : {b, a};
   endtask
   task automatic wait_evt();
      for (int i = 0; i < 40 && evt !== 1'b1; i++) @(negedge clk);
      chk({15'h0, evt}, 16'h0001);
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      reg_rd(SC, b1);
      chk({8'h00, b1}, 16'h0000);
      rd_cnt(CH, 0, v);
      chk(v, 16'h0000);
      reg_rd(4'hF, b1);
      chk({8'h00, b1}, 16'h0000);
      $display("Reset values done");
      for (int s = 1; s < 4; s++) begin
         for (int p = 0; p < 8; p++) begin
            reg_wr(SC, {3'b000, s[1:0], p[2:0]});
            reg_wr(CL, 8'h5A);
            repeat ((20 << p) * (s == 3 ? 8 : 1)) @(posedge clk);
            reg_wr(SC, 8'h00);
            rd_cnt(CL, 0, v);
            near(v, 16'd20);
         end
      end
      reg_wr(CL, 8'h00);
      repeat (50) @(posedge clk);
      rd_cnt(CH, 0, v);
      chk(v, 16'h0000);
      // Fixed clock with the loop running: gated by its own level, not the bus
      for (int f = 0; f < 2; f++) begin
         @(posedge clk);
         pll_en <= 1'b1;
         fix_tick <= f[0];
         reg_wr(CL, 8'h00);
         reg_wr(SC, 8'h10);
         repeat (20) @(posedge clk);
         reg_wr(SC, 8'h00);
         rd_cnt(CH, 0, v);
         chk(v, f[0] ? 16'h0016 : 16'h0000);
      end
      $display("Clock source and prescaler done");
      reg_wr(ML, 8'h05);
      reg_wr(CL, 8'h00);
      reg_wr(SC, 8'h48);
      wait_evt();
      reg_rd(SC, b1);
      chk({8'h00, b1}, 16'h00C8);
      chk({15'h0, irq}, 16'h0001);
      reg_wr(SC, 8'hC8);
      reg_rd(SC, b1);
      chk({15'h0, b1[7]}, 16'h0001);
      reg_rd(SC, b1);
      wait_evt();
      reg_wr(SC, 8'h48);
      reg_rd(SC, b1);
      chk({15'h0, b1[7]}, 16'h0001);
      reg_wr(SC, 8'h40);
      reg_rd(SC, b1);
      reg_wr(SC, 8'h40);
      reg_rd(SC, b1);
      chk({8'h00, b1}, 16'h0040);
      chk({15'h0, irq}, 16'h0000);
      $display("Overflow flag done");
      reg_wr(ML, 8'h00);
      for (int o = 1; o < 3; o++) begin
         reg_wr(SC, 8'h08);
         reg_wr(CL, 8'hFF);
         repeat (16'h17E) @(posedge clk);
         rd_cnt(o[3:0], 300, v);
         near(v, 16'h0180);
      end
      reg_wr(CL, 8'h00);
      repeat (16'h17E) @(posedge clk);
      reg_rd(CH, b1);
      reg_wr(SC, 8'h08);
      repeat (300) @(posedge clk);
      reg_rd(CL, b2);
      near({8'h00, b2}, 16'h00B0);
      $display("Coherent read done");
      reg_wr(CL, 8'h00);
      repeat (16'h17E) @(posedge clk);
      reg_rd(CH, b1);
      @(posedge clk);
      halt <= 1'b1;
      repeat (5) @(negedge clk);
      v = counter;
      reg_rd(CL, b2);
      near({8'h00, b2}, 16'h0080);
      repeat (50) @(negedge clk);
      chk(counter, v);
      @(posedge clk);
      halt <= 1'b0;
      repeat (5) @(posedge clk);
      reg_rd(CL, b2);
      near({8'h00, b2}, 16'h0080);
      $display("Debug halt done");
      reg_wr(ML, 8'h03);
      reg_wr(CL, 8'h00);
      reg_wr(SC, 8'h28);
      v = 16'h0000;
      seen = 1'b0;
      repeat (40) begin
         @(negedge clk);
         if (counter > v) v = counter;
         if (down === 1'b1) seen = 1'b1;
      end
      chk(v, 16'h0003);
      chk({15'h0, seen}, 16'h0001);
      chk({15'h0, center}, 16'h0001);
      $display("Center mode done");
      end_of_test();
   end
endmodule
